// ---- hw/csba_pkg.sv ----
// Package: register map, field positions and types of the serial channel
// Contract
// - Length select 1 means 16 bits, 0 means 8
// - Clock source 111B is slave, else master
// - Delay mode only in master mode
// - Continuous transfer needs access during reservation
// - Peek buffer reads never start reception
package csba_pkg;
    localparam logic [5:0] A_MODE = 6'h00;
    localparam logic [5:0] A_CLK  = 6'h04;
    localparam logic [5:0] A_TXW  = 6'h08;
    localparam logic [5:0] A_TXN  = 6'h0C;
    localparam logic [5:0] A_FTW  = 6'h10;
    localparam logic [5:0] A_FTN  = 6'h14;
    localparam logic [5:0] A_SRW  = 6'h18;
    localparam logic [5:0] A_SRN  = 6'h1C;
    localparam logic [5:0] A_RXW  = 6'h20;
    localparam logic [5:0] A_RXN  = 6'h24;
    localparam logic [5:0] A_PKW  = 6'h28;
    localparam logic [5:0] A_PKN  = 6'h2C;
    localparam int B_AUTO  = 0;
    localparam int B_LEN   = 1;
    localparam int B_DLY   = 2;
    localparam int B_ACT   = 4;
    localparam logic [2:0] CS_SLAVE = 3'h7;
    localparam logic [4:0] NB_WIDE  = 5'h10;
    localparam logic [4:0] NB_NARW  = 5'h08;
    localparam logic [4:0] RX_LAG   = 5'h02;
    localparam logic [15:0] RST_W   = 16'h0000;
    typedef struct packed {
        logic auto_xfer;
        logic len16;
        logic delay;
    } csba_mode_type;
    typedef struct packed {
        logic master;
        logic len16;
        logic delay;
    } csba_cfg_type;
    typedef enum logic [1:0] {
        L_IDLE  = 2'b00,
        L_DELAY = 2'b01,
        L_SHIFT = 2'b10
    } csba_lstate_type;
endpackage

// ---- hw/csba_top.sv ----
// Serial channel: AHB-Lite register side and link-clocked shifter
`timescale 1ns/1ps
module csba_top
    import csba_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_lclk,
    input  wire logic        i_lrst,
    input  wire logic        i_si,
    output logic             o_so,
    output logic             o_sck_oe,
    output logic             o_frame
);
    ////////////////////////////////////////////////////////////////////
    // Register side state
    csba_mode_type mode_q, mode_d;
    logic [2:0]  clksrc_q, clksrc_d;
    logic [15:0] txbuf_q, txbuf_d, final_q, final_d, rxbuf_q, rxbuf_d;
    logic        act_q, act_d, resv_q, resv_d, stgl_q, stgl_d;
    logic        ap_q, ap_d, apw_q, apw_d;
    logic [5:0]  apa_q, apa_d;
    logic [31:0] rdata_q, rdata_d;
    logic        rdy_q;
    logic        dn_s1, dn_s2, dn_s3;
    logic        acc, rd, wdp, wr_tx, rd_rx, rd_pk, kick, done_p;
    logic        ctl_ok;
    logic [15:0] wdat;
    // Link side state
    csba_lstate_type st_q, st_d;
    csba_cfg_type cfg_s1, cfg_s2, cfg_in;
    logic [4:0]  cnt_q, cnt_d, nb;
    logic [15:0] tsh_q, tsh_d, rsh_q, rsh_d;
    logic        so_q, so_d, fr_q, fr_d, dtgl_q, dtgl_d, oe_q;
    logic        st_s1, st_s2, st_s3, si_s1, si_s2;

    ////////////////////////////////////////////////////////////////////
    // Bus decode; every access is zero wait, so hready is ours too
    assign acc    = i_hsel & i_htrans[1] & i_hready;
    assign rd     = acc & ~i_hwrite;
    assign wdp    = ap_q & apw_q;
    assign wdat   = i_hwdata[15:0];
    assign done_p = dn_s2 ^ dn_s3;
    // Narrow views only act in 8-bit length, wide in 16-bit
    assign wr_tx  = wdp & ((apa_q == A_TXW & mode_q.len16) |
                           (apa_q == A_TXN & ~mode_q.len16));
    assign rd_rx  = rd & ((i_haddr[5:0] == A_RXW & mode_q.len16) |
                          (i_haddr[5:0] == A_RXN & ~mode_q.len16));
    // Peek views are plain reads with no transfer trigger
    assign rd_pk  = rd & (i_haddr[5:0] == A_PKW |
                          i_haddr[5:0] == A_PKN);
    assign kick   = wr_tx | rd_rx;
    // Control registers are frozen while a transfer runs
    assign ctl_ok = ~act_q;

    // Next values of the register side
    always_comb
    begin
        ap_d     = acc;
        apw_d    = i_hwrite;
        apa_d    = i_haddr[5:0];
        mode_d   = mode_q;
        clksrc_d = clksrc_q;
        txbuf_d  = txbuf_q;
        final_d  = final_q;
        rxbuf_d  = rxbuf_q;
        act_d    = act_q;
        resv_d   = resv_q;
        stgl_d   = stgl_q;
        if (wdp && ctl_ok && apa_q == A_MODE)
        begin
            mode_d.auto_xfer = i_hwdata[B_AUTO];
            mode_d.len16     = i_hwdata[B_LEN];
            // Delay mode cannot be set while slave is selected
            mode_d.delay = i_hwdata[B_DLY] & (clksrc_q != CS_SLAVE);
        end
        if (wdp && ctl_ok && apa_q == A_CLK)
        begin
            clksrc_d = i_hwdata[2:0];
            if (i_hwdata[2:0] == CS_SLAVE)
            begin
                mode_d.delay = 1'b0;
            end
        end
        // Stored even mid-transfer; contents then undefined for software
        if (wr_tx)
        begin
            txbuf_d = mode_q.len16 ? wdat : {8'h00, wdat[7:0]};
        end
        if (wdp && ctl_ok && (apa_q == A_FTW & mode_q.len16 |
                              apa_q == A_FTN & ~mode_q.len16))
        begin
            final_d = mode_q.len16 ? wdat : {8'h00, wdat[7:0]};
        end
        if (done_p)
        begin
            rxbuf_d = rsh_q;
        end
        // Access during a run reserves the next word in continuous mode
        if (act_q && kick && mode_q.auto_xfer)
        begin
            resv_d = 1'b1;
        end
        if (~act_q && kick)
        begin
            act_d   = 1'b1;
            stgl_d  = ~stgl_q;
            final_d = txbuf_d;
        end
        else if (done_p)
        begin
            if (mode_q.auto_xfer && (resv_q || kick))
            begin
                stgl_d  = ~stgl_q;
                final_d = txbuf_d;
                resv_d  = 1'b0;
            end
            else
            begin
                act_d  = 1'b0;
                resv_d = 1'b0;
            end
        end
    end

    // Read data mux; shift register is read without crossing, valid idle
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (i_haddr[5:0])
            A_MODE: rdata_d = {27'h000_0000, act_q, 1'b0,
                               mode_q.delay, mode_q.len16,
                               mode_q.auto_xfer};
            A_CLK: rdata_d = {29'h0000_0000, clksrc_q};
            A_TXW: rdata_d = {16'h0000, txbuf_q};
            A_TXN: rdata_d = {24'h00_0000, txbuf_q[7:0]};
            A_FTW: rdata_d = {16'h0000, final_q};
            A_FTN: rdata_d = {24'h00_0000, final_q[7:0]};
            A_SRW: rdata_d = {16'h0000, rsh_q};
            A_SRN: rdata_d = {24'h00_0000, rsh_q[7:0]};
            A_RXW, A_PKW: rdata_d = {16'h0000, rxbuf_q};
            A_RXN, A_PKN: rdata_d = {24'h00_0000, rxbuf_q[7:0]};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Register side flops; done toggle crosses through two stages
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            mode_q   <= '0;
            clksrc_q <= 3'h0;
            txbuf_q  <= RST_W;
            final_q  <= RST_W;
            rxbuf_q  <= RST_W;
            act_q    <= 1'b0;
            resv_q   <= 1'b0;
            stgl_q   <= 1'b0;
            ap_q     <= 1'b0;
            apw_q    <= 1'b0;
            apa_q    <= 6'h00;
            rdata_q  <= 32'h0000_0000;
            rdy_q    <= 1'b0;
            dn_s1    <= 1'b0;
            dn_s2    <= 1'b0;
            dn_s3    <= 1'b0;
        end
        else
        begin
            mode_q   <= mode_d;
            clksrc_q <= clksrc_d;
            txbuf_q  <= txbuf_d;
            final_q  <= final_d;
            rxbuf_q  <= rxbuf_d;
            act_q    <= act_d;
            resv_q   <= resv_d;
            stgl_q   <= stgl_d;
            ap_q     <= ap_d;
            apw_q    <= apw_d;
            apa_q    <= apa_d;
            rdata_q  <= rdata_d;
            rdy_q    <= 1'b1;
            dn_s1    <= dtgl_q;
            dn_s2    <= dn_s1;
            dn_s3    <= dn_s2;
        end
    end

    assign o_hrdata    = rdata_q;
    assign o_hreadyout = rdy_q;
    assign o_hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Link side: config is static while active, so a level sync suffices
    assign cfg_in = '{master: clksrc_q != CS_SLAVE,
                      len16:  mode_q.len16,
                      delay:  mode_q.delay};
    assign nb     = cfg_s2.len16 ? NB_WIDE : NB_NARW;

    // Shifter: MSB first; receive lags two cycles for the pin sync
    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        tsh_d  = tsh_q;
        rsh_d  = rsh_q;
        so_d   = so_q;
        fr_d   = fr_q;
        dtgl_d = dtgl_q;
        case (st_q)
            L_IDLE:
            begin
                if (st_s2 ^ st_s3)
                begin
                    tsh_d = cfg_s2.len16 ? final_q
                                         : {final_q[7:0], 8'h00};
                    rsh_d = RST_W;
                    cnt_d = 5'h00;
                    fr_d  = 1'b1;
                    // Delay only honoured when this end is master
                    st_d  = (cfg_s2.delay & cfg_s2.master) ? L_DELAY
                                                            : L_SHIFT;
                end
            end
            L_DELAY: st_d = L_SHIFT;
            L_SHIFT:
            begin
                if (cnt_q < nb)
                begin
                    so_d  = tsh_q[15];
                    tsh_d = {tsh_q[14:0], 1'b0};
                end
                if (cnt_q >= RX_LAG)
                begin
                    rsh_d = {rsh_q[14:0], si_s2};
                end
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == nb + 5'h01)
                begin
                    st_d   = L_IDLE;
                    fr_d   = 1'b0;
                    dtgl_d = ~dtgl_q;
                end
            end
            default: st_d = L_IDLE;
        endcase
    end

    // Link flops; start toggle and serial input each pass two stages
    always_ff @(posedge i_lclk)
    begin
        if (i_lrst)
        begin
            st_q   <= L_IDLE;
            cnt_q  <= 5'h00;
            tsh_q  <= RST_W;
            rsh_q  <= RST_W;
            so_q   <= 1'b0;
            fr_q   <= 1'b0;
            dtgl_q <= 1'b0;
            oe_q   <= 1'b0;
            cfg_s1 <= '0;
            cfg_s2 <= '0;
            st_s1  <= 1'b0;
            st_s2  <= 1'b0;
            st_s3  <= 1'b0;
            si_s1  <= 1'b0;
            si_s2  <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            tsh_q  <= tsh_d;
            rsh_q  <= rsh_d;
            so_q   <= so_d;
            fr_q   <= fr_d;
            dtgl_q <= dtgl_d;
            oe_q   <= cfg_s2.master;
            cfg_s1 <= cfg_in;
            cfg_s2 <= cfg_s1;
            st_s1  <= stgl_q;
            st_s2  <= st_s1;
            st_s3  <= st_s2;
            si_s1  <= i_si;
            si_s2  <= si_s1;
        end
    end

    assign o_so     = so_q;
    assign o_sck_oe = oe_q;
    assign o_frame  = fr_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_slave_nodelay: assert property (@(posedge i_mclk) disable iff (i_rst)
        clksrc_q == CS_SLAVE |-> !mode_q.delay)
        else $error("delay mode set in slave mode");
    a_ctrl_frozen: assert property (@(posedge i_mclk) disable iff (i_rst)
        act_q && wdp && apa_q == A_MODE |=> $stable(mode_q))
        else $error("mode changed during transfer");
    a_narrow_ignored: assert property (@(posedge i_mclk) disable iff (i_rst)
        wdp && apa_q == A_TXN && mode_q.len16 && !done_p
        |=> $stable(txbuf_q))
        else $error("narrow view wrote in 16-bit length");
    a_peek_nostart: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_pk && !act_q && !wdp |=> !act_q)
        else $error("peek read started a transfer");
    a_start_active: assert property (@(posedge i_mclk) disable iff (i_rst)
        !act_q && kick |=> act_q && stgl_q != $past(stgl_q))
        else $error("start did not raise active flag");
    a_resv_continue: assert property (@(posedge i_mclk) disable iff (i_rst)
        done_p && mode_q.auto_xfer && resv_q |=> act_q)
        else $error("reserved continuous transfer stopped");
    a_unresv_stop: assert property (@(posedge i_mclk) disable iff (i_rst)
        done_p && !resv_q && !kick |=> !act_q)
        else $error("transfer continued without reservation");
    a_master_oe: assert property (@(posedge i_lclk) disable iff (i_lrst)
        $rose(fr_q) |-> o_sck_oe == cfg_s2.master)
        else $error("clock ownership does not match mode");
    a_frame_len: assert property (@(posedge i_lclk) disable iff (i_lrst)
        $rose(fr_q) |-> fr_q [*8])
        else $error("frame shorter than a narrow word");
    a_frame_end: assert property (@(posedge i_lclk) disable iff (i_lrst)
        st_q == L_SHIFT && cnt_q == nb + 5'h01
        |=> !fr_q && dtgl_q != $past(dtgl_q))
        else $error("frame did not close after last bit");
    c_wide: cover property (@(posedge i_lclk) disable iff (i_lrst)
        $fell(fr_q) && cfg_s2.len16);
    c_delay: cover property (@(posedge i_lclk) disable iff (i_lrst)
        st_q == L_DELAY);
    c_chain: cover property (@(posedge i_mclk) disable iff (i_rst)
        done_p && resv_q ##1 act_q);
endmodule

// ---- bench/csba_remote.sv ----
// Remote serial device model: answers with a fixed word, records the wire
`timescale 1ns/1ps
module csba_remote
    import csba_pkg::*;
(
    input  wire logic        i_lclk,
    input  wire logic        i_rst,
    input  wire logic        i_frame,
    input  wire logic        i_so,
    input  wire logic        i_len16,
    input  wire logic        i_delay,
    input  wire logic [15:0] i_word,
    output logic             o_si = 1'b0,
    output logic      [17:0] o_cap
);
    int cnt;
    int idx;
    int nb;
    ////////////////////////////////////////////////////////////////////////
    // The device takes each bit one cycle before it shows its own, so the
    // model leads by one: the first bit already waits on the idle line
    always @(posedge i_lclk)
    begin
        nb  = i_len16 ? 16 : 8;
        idx = cnt + 1 - int'(i_delay);
        if (i_rst || !i_frame)
            cnt <= 0;
        else
            cnt <= cnt + 1;
        if (i_frame && idx >= 0 && idx < nb)
            o_si <= i_word[nb - 1 - idx];
        else
            o_si <= i_word[nb - 1];
    end
    // Sample mid-cycle, away from the edge where the device moves its bit
    always @(negedge i_lclk)
    begin
        if (i_rst)
            o_cap <= 18'h0_0000;
        else if (i_frame)
            o_cap <= {o_cap[16:0], i_so};
    end
endmodule

// ---- bench/clocked_serial_buffer_access_test.sv ----
// Testbench: register-side sequences against the remote device model
`timescale 1ns/1ps
module clocked_serial_buffer_access_test;
    import csba_pkg::*;
    logic        mclk   = 1'b0;
    logic        lclk   = 1'b0;
    logic        rst    = 1'b1;
    logic        lrst   = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        len16  = 1'b0;
    logic        dly    = 1'b0;
    logic [15:0] word   = 16'h0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [17:0] cap;
    logic        hready;
    logic        hresp;
    logic        si;
    logic        so;
    logic        sck_oe;
    logic        frame;
    int          miscompares = 0;
    int          n_checks    = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clocks; the link clock starts off-grid so the phases never line up
    always #2 mclk = ~mclk;
    initial
    begin
        #1.3;
        forever #32 lclk = ~lclk;
    end
    csba_top DUT (.i_mclk(mclk), .i_rst(rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_lclk(lclk), .i_lrst(lrst), .i_si(si), .o_so(so),
        .o_sck_oe(sck_oe), .o_frame(frame));
    csba_remote rem (.i_lclk(lclk), .i_rst(lrst), .i_frame(frame),
        .i_so(so), .i_len16(len16), .i_delay(dly), .i_word(word),
        .o_si(si), .o_cap(cap));
    ////////////////////////////////////////////////////////////////////////
    // Comparison, bus cycle and end-of-run helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address phase held until hready, then data phase held until hready
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {26'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdv(input logic [5:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // Poll the active flag with a bound; running out shows as a mismatch
    task automatic wait_idle();
        int k;
        k = 0;
        rdv(A_MODE);
        while (rd[B_ACT] !== 1'b0 && k < 1000)
        begin
            rdv(A_MODE);
            k++;
        end
        chk({31'h0, rd[B_ACT]}, 32'h0000_0000);
    endtask
    // One single word: start, refused writes while busy, then idle reads
    task automatic send(input logic [5:0] txa, input logic [15:0] d,
                        input int n);
        logic [15:0] m;
        m = (n == 16) ? 16'hFFFF : 16'h00FF;
        wr(txa, {16'h0, d});
        rdv(A_MODE);
        chk({31'h0, rd[B_ACT]}, 32'h0000_0001);
        wr(A_CLK, 32'h0000_0007);
        wr(txa + 6'h08, {16'h0, ~d & m});
        wait_idle();
        chk({16'h0, (n == 16) ? cap[16:1] : {8'h0, cap[8:1]}},
            {16'h0, d});
        rdv(txa + 6'h08);
        chk(rd, {16'h0, d});
        rdv(txa + 6'h10);
        chk(rd, {16'h0, word & m});
        rdv(txa + 6'h20);
        chk(rd, {16'h0, word & m});
        rdv(A_MODE);
        chk({31'h0, rd[B_ACT]}, 32'h0000_0000);
        chk({31'h0, frame}, 32'h0000_0000);
        rdv(A_CLK);
        chk(rd, 32'h0000_0000);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs about 5 us
    initial
    begin
        #200000;
        miscompares++;
        conclude();
    end
    // Main sequence
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge lclk);
        lrst <= 1'b0;
        repeat (4) @(posedge lclk);
        @(posedge mclk);
        chk({31'h0, hready}, 32'h0000_0001);
        chk({31'h0, hresp}, 32'h0000_0000);
        rdv(A_MODE);
        chk(rd, 32'h0000_0000);
        chk({31'h0, sck_oe}, 32'h0000_0001);
        $display("test reset done");
        len16 <= 1'b1;
        word  <= 16'h3C5A;
        wr(A_MODE, 32'h0000_0002);
        send(A_TXW, 16'hA5C3, 16);
        wr(A_TXN, 32'h0000_0055);
        rdv(A_MODE);
        chk({31'h0, rd[B_ACT]}, 32'h0000_0000);
        $display("test wide word done");
        len16 <= 1'b0;
        dly   <= 1'b1;
        word  <= 16'h00B4;
        wr(A_MODE, 32'h0000_0004);
        rdv(A_MODE);
        chk(rd, 32'h0000_0004);
        send(A_TXN, 16'h0096, 8);
        $display("test narrow delayed word done");
        dly <= 1'b0;
        wr(A_MODE, 32'h0000_0001);
        wr(A_TXN, 32'h0000_0011);
        wr(A_TXN, 32'h0000_0022);
        wait_idle();
        chk({24'h0, cap[8:1]}, 32'h0000_0022);
        $display("test continuous done");
        wr(A_MODE, 32'h0000_0000);
        wr(A_CLK, 32'h0000_0007);
        repeat (4) @(posedge lclk);
        @(posedge mclk);
        chk({31'h0, sck_oe}, 32'h0000_0000);
        wr(A_MODE, 32'h0000_0004);
        rdv(A_MODE);
        chk(rd, 32'h0000_0000);
        rdv(6'h30);
        chk(rd, 32'h0000_0000);
        wr(A_CLK, 32'h0000_0006);
        repeat (4) @(posedge lclk);
        @(posedge mclk);
        chk({31'h0, sck_oe}, 32'h0000_0001);
        $display("test clock source done");
        conclude();
    end
endmodule
